// *** src/ciopd_pkg.sv ***
// Package holding the constants and types of the configurable port driver block.
// Notes on behaviour
// - Three ports, each pin configured on its own.
// - Two selection registers per port, bit y each.
// - Codes ab: 00 quasi, 01 push, 10 input, 11 drain.
// - Quasi is default, acts as input and output.
// - Quasi: very weak pull-up while latch holds one.
// - Quasi: weak pull-up while latch and pin high.
// - Quasi: latch rising gives two-clock strong pull-up.
// - Open drain: no pull-ups, pull-down on latch zero.
// - Push-pull: pull-down on zero, strong on one.
// - Input only: no pull-up and no pull-down.
// - Reset clears all selection register bits.
// - Bus variant: read strobe bit one, write bit zero.
package ciopd_pkg;

  // Number of ports and pins per port.
  localparam int NUM_PORTS = 3;
  localparam int PORT_WIDTH = 8;

  // Port indices inside the packed arrays.
  localparam logic [1:0] PORT_ONE_IDX = 2'h0;
  localparam logic [1:0] PORT_THREE_IDX = 2'h1;
  localparam logic [1:0] PORT_FOUR_IDX = 2'h2;

  // Register addresses on the special function register bus.
  localparam logic [7:0] PORT1_TYPE_SEL_A_ADDR = 8'hD4;
  localparam logic [7:0] PORT3_TYPE_SEL_A_ADDR = 8'hD5;
  localparam logic [7:0] PORT4_TYPE_SEL_A_ADDR = 8'hD6;
  localparam logic [7:0] PORT1_TYPE_SEL_B_ADDR = 8'hE2;
  localparam logic [7:0] PORT3_TYPE_SEL_B_ADDR = 8'hE4;
  localparam logic [7:0] PORT4_TYPE_SEL_B_ADDR = 8'hE5;

  // Values after reset.
  localparam logic [7:0] TYPE_SEL_RESET = 8'h00;
  localparam logic [7:0] RDATA_RESET = 8'h00;

  // Bit positions of the external strobes on port one.
  localparam int PORT_ONE_BIT_ONE = 1;
  localparam int PORT_ONE_BIT_ZERO = 0;

  // Length of the strong pull-up pulse in CPU clocks.
  localparam logic [1:0] STRONG_PULSE_CYC = 2'h2;
  localparam logic [1:0] STRONG_CNT_RESET = 2'h0;

  // Output type of one pin.
  typedef enum logic [1:0] {
    MODE_QUASI,
    MODE_PUSH_PULL,
    MODE_INPUT_ONLY,
    MODE_OPEN_DRAIN
  } ciopd_mode_t;

  // Driver enables of one port, one bit per pin.
  typedef struct packed {
    logic [7:0] pu_vweak;
    logic [7:0] pu_weak;
    logic [7:0] pu_strong;
    logic [7:0] pull_down;
  } ciopd_drv_t;

  // Result of decoding a register address.
  typedef struct packed {
    logic hit;
    logic sel_b;
    logic [1:0] port;
  } ciopd_dec_t;

endpackage

// *** src/ciopd_top.sv ***
// Per-pin output type control and pull-up sequencing for three eight-bit ports.
`timescale 1ns/1ps
`default_nettype none

module ciopd_top (
  // Clock and synchronous reset.
  input wire logic clk,
  input wire logic resetn,
  // Special function register bus, same clock as the CPU.
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  output var logic [7:0] sfr_rdata,
  output var logic sfr_hit,
  // Port output latches from the CPU, index 0 port one, 1 port three, 2 port four.
  input wire logic [2:0][7:0] port_latch,
  // External bus variant: strobes replace port one bits one and zero.
  input wire logic ext_bus_mode,
  input wire logic ext_rd_n,
  input wire logic ext_wr_n,
  // Raw pin levels from the input buffers.
  input wire logic [2:0][7:0] pin_in,
  // Synchronised pin levels and driver enables.
  output var logic [2:0][7:0] pin_level,
  output var ciopd_pkg::ciopd_drv_t [2:0] pin_drv
);

  // Selection register state.
  logic [2:0][7:0] sel_a_reg;
  logic [2:0][7:0] sel_a_next;
  logic [2:0][7:0] sel_b_reg;
  logic [2:0][7:0] sel_b_next;
  logic [7:0] rdata_next;
  logic hit_next;

  // Pin synchroniser state.
  logic [2:0][7:0] sync1_reg;
  logic [2:0][7:0] sync2_reg;
  logic [2:0][7:0] sync3_reg;
  logic [2:0][7:0] level_next;

  // Effective latch, previous latch and driver state.
  logic [2:0][7:0] latch_eff;
  logic [2:0][7:0] latch_prev_reg;
  ciopd_pkg::ciopd_drv_t [2:0] drv_next;

  // Maps a bus address onto one selection register.
  function automatic ciopd_pkg::ciopd_dec_t ciopd_decode(input logic [7:0] addr);
    ciopd_pkg::ciopd_dec_t d;
    d = '0;
    unique case (addr)
      ciopd_pkg::PORT1_TYPE_SEL_A_ADDR: d = '{1'b1, 1'b0, ciopd_pkg::PORT_ONE_IDX};
      ciopd_pkg::PORT3_TYPE_SEL_A_ADDR: d = '{1'b1, 1'b0, ciopd_pkg::PORT_THREE_IDX};
      ciopd_pkg::PORT4_TYPE_SEL_A_ADDR: d = '{1'b1, 1'b0, ciopd_pkg::PORT_FOUR_IDX};
      ciopd_pkg::PORT1_TYPE_SEL_B_ADDR: d = '{1'b1, 1'b1, ciopd_pkg::PORT_ONE_IDX};
      ciopd_pkg::PORT3_TYPE_SEL_B_ADDR: d = '{1'b1, 1'b1, ciopd_pkg::PORT_THREE_IDX};
      ciopd_pkg::PORT4_TYPE_SEL_B_ADDR: d = '{1'b1, 1'b1, ciopd_pkg::PORT_FOUR_IDX};
      default: d = '0;
    endcase
    return d;
  endfunction

  // Turns the two selection bits of a pin into its output type.
  function automatic ciopd_pkg::ciopd_mode_t ciopd_mode(input logic a, input logic b);
    ciopd_pkg::ciopd_mode_t m;
    unique case ({a, b})
      2'b00: m = ciopd_pkg::MODE_QUASI;
      2'b01: m = ciopd_pkg::MODE_PUSH_PULL;
      2'b10: m = ciopd_pkg::MODE_INPUT_ONLY;
      2'b11: m = ciopd_pkg::MODE_OPEN_DRAIN;
    endcase
    return m;
  endfunction

  // Register writes replace the whole byte; reads return it the next cycle, unmapped reads give zero.
  always_comb begin
    ciopd_pkg::ciopd_dec_t wdec;
    ciopd_pkg::ciopd_dec_t rdec;
    wdec = ciopd_decode(sfr_addr);
    rdec = wdec;
    sel_a_next = sel_a_reg;
    sel_b_next = sel_b_reg;
    rdata_next = ciopd_pkg::RDATA_RESET;
    hit_next = 1'b0;
    if (sfr_wr && wdec.hit) begin
      if (wdec.sel_b) begin
        sel_b_next[wdec.port] = sfr_wdata;
      end else begin
        sel_a_next[wdec.port] = sfr_wdata;
      end
    end
    if (sfr_rd && rdec.hit) begin
      rdata_next = rdec.sel_b ? sel_b_reg[rdec.port] : sel_a_reg[rdec.port];
      hit_next = 1'b1;
    end
  end

  // Reset leaves every pin quasi-bidirectional, including the undefined port one low bits.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sel_a_reg <= {3{ciopd_pkg::TYPE_SEL_RESET}};
      sel_b_reg <= {3{ciopd_pkg::TYPE_SEL_RESET}};
      sfr_rdata <= ciopd_pkg::RDATA_RESET;
      sfr_hit <= 1'b0;
    end else begin
      sel_a_reg <= sel_a_next;
      sel_b_reg <= sel_b_next;
      sfr_rdata <= rdata_next;
      sfr_hit <= hit_next;
    end
  end

  // A level change counts only once the second and third stages agree, which filters a late edge.
  always_comb begin
    level_next = pin_level;
    for (int p = 0; p < ciopd_pkg::NUM_PORTS; p++) begin
      for (int b = 0; b < ciopd_pkg::PORT_WIDTH; b++) begin
        if (sync2_reg[p][b] == sync3_reg[p][b]) begin
          level_next[p][b] = sync3_reg[p][b];
        end
      end
    end
  end

  // Three-stage synchroniser; the first stage feeds only the second.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
      pin_level <= '0;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      pin_level <= level_next;
    end
  end

  // In the bus variant the strobes take the latch place of port one bits one and zero.
  always_comb begin
    latch_eff = port_latch;
    if (ext_bus_mode) begin
      latch_eff[ciopd_pkg::PORT_ONE_IDX][ciopd_pkg::PORT_ONE_BIT_ONE] = ext_rd_n;
      latch_eff[ciopd_pkg::PORT_ONE_IDX][ciopd_pkg::PORT_ONE_BIT_ZERO] = ext_wr_n;
    end
  end

  // Previous latch value, used to find the low-to-high change.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      latch_prev_reg <= '0;
    end else begin
      latch_prev_reg <= latch_eff;
    end
  end

  // One driver slice per pin of each port.
  for (genvar gp = 0; gp < ciopd_pkg::NUM_PORTS; gp++) begin : g_port
    for (genvar gb = 0; gb < ciopd_pkg::PORT_WIDTH; gb++) begin : g_pin
      logic [1:0] cnt_reg;
      logic [1:0] cnt_next;
      ciopd_pkg::ciopd_mode_t mode;
      logic latch;
      logic level;

      assign mode = ciopd_mode(sel_a_reg[gp][gb], sel_b_reg[gp][gb]);
      assign latch = latch_eff[gp][gb];
      assign level = pin_level[gp][gb];

      // The strong pulse restarts on every rising latch and dies if the latch falls or the type changes.
      always_comb begin
        cnt_next = ciopd_pkg::STRONG_CNT_RESET;
        if (mode == ciopd_pkg::MODE_QUASI && latch) begin
          if (!latch_prev_reg[gp][gb]) begin
            cnt_next = ciopd_pkg::STRONG_PULSE_CYC;
          end else if (cnt_reg != ciopd_pkg::STRONG_CNT_RESET) begin
            cnt_next = cnt_reg - 2'h1;
          end
        end
      end

      // Enables follow from type, latch, sensed level and pulse counter; registered so outputs are glitch free.
      always_comb begin
        drv_next[gp].pu_vweak[gb] = 1'b0;
        drv_next[gp].pu_weak[gb] = 1'b0;
        drv_next[gp].pu_strong[gb] = 1'b0;
        drv_next[gp].pull_down[gb] = 1'b0;
        unique case (mode)
          ciopd_pkg::MODE_QUASI: begin
            drv_next[gp].pu_vweak[gb] = latch;
            drv_next[gp].pu_weak[gb] = latch & level;
            drv_next[gp].pu_strong[gb] = (cnt_next != ciopd_pkg::STRONG_CNT_RESET);
            drv_next[gp].pull_down[gb] = ~latch;
          end
          ciopd_pkg::MODE_PUSH_PULL: begin
            drv_next[gp].pu_strong[gb] = latch;
            drv_next[gp].pull_down[gb] = ~latch;
          end
          ciopd_pkg::MODE_OPEN_DRAIN: begin
            drv_next[gp].pull_down[gb] = ~latch;
          end
          ciopd_pkg::MODE_INPUT_ONLY: begin
            drv_next[gp].pull_down[gb] = 1'b0;
          end
        endcase
      end

      // Counter and enable registers of this pin.
      always_ff @(posedge clk) begin
        if (!resetn) begin
          cnt_reg <= ciopd_pkg::STRONG_CNT_RESET;
          pin_drv[gp].pu_vweak[gb] <= 1'b0;
          pin_drv[gp].pu_weak[gb] <= 1'b0;
          pin_drv[gp].pu_strong[gb] <= 1'b0;
          pin_drv[gp].pull_down[gb] <= 1'b0;
        end else begin
          cnt_reg <= cnt_next;
          pin_drv[gp].pu_vweak[gb] <= drv_next[gp].pu_vweak[gb];
          pin_drv[gp].pu_weak[gb] <= drv_next[gp].pu_weak[gb];
          pin_drv[gp].pu_strong[gb] <= drv_next[gp].pu_strong[gb];
          pin_drv[gp].pull_down[gb] <= drv_next[gp].pull_down[gb];
        end
      end
    end
  end

endmodule

`default_nettype wire

// *** tb/ciopd_top_asserts.sv ***
// Checker of register bus and driver relations of the port driver block.
`timescale 1ns/1ps
`default_nettype none
module ciopd_top_asserts (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Register bus.
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_hit,
  // Pins.
  input wire logic [2:0][7:0] pin_in,
  input wire logic [2:0][7:0] pin_level,
  input wire ciopd_pkg::ciopd_drv_t [2:0] pin_drv
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Decode of the six selection registers.
  logic mapped;
  assign mapped = sfr_addr inside {8'hD4, 8'hD5, 8'hD6, 8'hE2, 8'hE4, 8'hE5};
  // Read answers stand for one cycle only.
  a_read_hit: assert property (sfr_rd && mapped |=> sfr_hit) else $error("no hit on read");
  a_read_unmapped: assert property (sfr_rd && !mapped |=> !sfr_hit && sfr_rdata == 8'h00) else $error("bad read");
  a_read_idle: assert property (!sfr_rd |=> !sfr_hit && sfr_rdata == 8'h00) else $error("stray read data");
  a_write_back: assert property (sfr_wr && mapped ##1 sfr_rd && $stable(sfr_addr) |=>
    sfr_rdata == $past(sfr_wdata, 2)) else $error("read back differs");
  // Four stable samples are more than the synchroniser needs.
  a_level_sync: assert property ($stable(pin_in) [*4] |=> pin_level == $past(pin_in)) else $error("level stale");
  // Driver enables of each port.
  for (genvar p = 0; p < 3; p++) begin : g_port
    logic [7:0] pulse;
    assign pulse = pin_drv[p].pu_strong & pin_drv[p].pu_vweak;
    a_no_fight: assert property ((pin_drv[p].pu_strong & pin_drv[p].pull_down) == 8'h00) else $error("fight");
    a_weak_vweak: assert property ((pin_drv[p].pu_weak & ~pin_drv[p].pu_vweak) == 8'h00) else $error("weak alone");
    a_weak_level: assert property ((pin_drv[p].pu_weak & ~$past(pin_level[p])) == 8'h00) else $error("weak on low");
    a_pulse_max: assert property ((pulse & $past(pulse) & $past(pulse, 2)) == 8'h00) else $error("pulse long");
  end
  // Main scenarios.
  c_read: cover property (sfr_rd && mapped ##1 sfr_hit);
  c_pulse: cover property (|pin_drv[0].pu_strong ##1 |pin_drv[0].pu_strong);
  c_weak: cover property (|pin_drv[2].pu_weak);
endmodule
`default_nettype wire

// *** tb/ciopd_pin_model.sv ***
// Behavioural model of the circuitry on the port pins.
`timescale 1ns/1ps
`default_nettype none
module ciopd_pin_model (
  // Clock.
  input wire logic clk,
  // Driver enables and external pull-downs.
  input wire ciopd_pkg::ciopd_drv_t [2:0] drv,
  input wire logic [2:0][7:0] ext_low,
  // Resolved pin levels.
  output logic [2:0][7:0] pin
);
  logic [7:0] flt = 8'h00;
  // A floating pin toggles every cycle on bits 0, 2, 5 and 7 and stays low on bits 1, 3, 4 and 6.
  always @(posedge clk) flt <= ~flt ^ 8'h5A;
  // Any pull-down wins over the pull-ups.
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      pin[p] = ~(ext_low[p] | drv[p].pull_down) & (drv[p].pu_vweak | drv[p].pu_weak | drv[p].pu_strong | flt);
    end
  end
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking testbench of the port driver block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0, resetn = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0, sfr_hit, rd_d = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, va, vb, l, lo;
  logic ext_bus_mode = 1'b0, ext_rd_n = 1'b1, ext_wr_n = 1'b1;
  logic [2:0][7:0] port_latch = 24'h0, ext_low = 24'h0, pin_in, pin_level;
  ciopd_pkg::ciopd_drv_t [2:0] pin_drv;
  int error_cnt = 0, samples_checked = 0;
  logic [8:0] exp_q[$];
  localparam logic [7:0] ADDR_A [3] = '{8'hD4, 8'hD5, 8'hD6};
  localparam logic [7:0] ADDR_B [3] = '{8'hE2, 8'hE4, 8'hE5};
  ciopd_top ciopd_top_inst (.clk(clk), .resetn(resetn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
    .port_latch(port_latch), .ext_bus_mode(ext_bus_mode), .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n),
    .pin_in(pin_in), .pin_level(pin_level), .pin_drv(pin_drv));
  ciopd_pin_model ciopd_pin_model_inst (.clk(clk), .drv(pin_drv), .ext_low(ext_low), .pin(pin_in));
  initial forever #12.5 clk = ~clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    samples_checked++;
    if (seen !== expv) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, expv);
    end
  endtask
  task automatic finish_test();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Op 0 idle, 1 write, 2 read of a mapped and 3 of an unmapped place; held one cycle.
  task automatic bus(input logic [1:0] op, input logic [7:0] a, input logic [7:0] d);
    sfr_wr <= op == 2'h1;
    sfr_rd <= op[1];
    sfr_addr <= a;
    sfr_wdata <= d;
    if (op[1]) exp_q.push_back({op == 2'h2, d});
    @(posedge clk);
  endtask
  // The unmapped write goes first, so the zero reads also show that it changed nothing.
  task automatic read_zero();
    bus(2'h1, 8'hD7, 8'hFF);
    for (int p = 0; p < 3; p++) begin
      bus(2'h2, ADDR_A[p], 8'h00);
      bus(2'h2, ADDR_B[p], 8'h00);
    end
    bus(2'h3, 8'hD7, 8'h00);
  endtask
  // Enables expected per pin type, with the external pull-downs in lo.
  function automatic logic [31:0] exp_drv(input logic [1:0] c, input logic [7:0] l, input logic [7:0] lo);
    case (c)
      2'h0: return {l, l & ~lo, 8'h00, ~l};
      2'h1: return {16'h0000, l, ~l};
      2'h2: return 32'h00000000;
      default: return {24'h000000, ~l};
    endcase
  endfunction
  // Each read is answered one cycle later; the oldest note holds the answer.
  always @(posedge clk) begin
    if (rd_d) check(32'({sfr_hit, sfr_rdata}), 32'(exp_q.pop_front()));
    rd_d <= sfr_rd && resetn;
  end
  initial begin
    #100000;
    error_cnt++;
    finish_test();
  end
  initial begin
    void'($urandom(32'hdf0df416));
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    read_zero();
    // Back-to-back writes and reads with random bytes; the second write must leave the first register alone.
    for (int p = 0; p < 3; p++) begin
      va = 8'($urandom);
      vb = 8'($urandom);
      bus(2'h1, ADDR_A[p], va);
      bus(2'h2, ADDR_A[p], va);
      bus(2'h1, ADDR_B[p], vb);
      bus(2'h2, ADDR_B[p], vb);
      bus(2'h2, ADDR_A[p], va);
    end
    // Every pin type on every port with random latches and external loads.
    for (int p = 0; p < 3; p++) begin
      for (int c = 0; c < 4; c++) begin
        bus(2'h1, ADDR_A[p], {8{c[1]}});
        bus(2'h1, ADDR_B[p], {8{c[0]}});
        bus(2'h0, 8'h00, 8'h00);
        port_latch <= 24'($urandom);
        ext_low <= 24'($urandom);
        ext_bus_mode <= 1'($urandom);
        ext_rd_n <= 1'($urandom);
        ext_wr_n <= 1'($urandom);
        repeat (8) @(posedge clk);
        l = port_latch[p];
        lo = ext_low[p];
        if (p == 0 && ext_bus_mode) l[1:0] = {ext_rd_n, ext_wr_n};
        check(pin_drv[p], exp_drv(2'(c), l, lo));
        if (c < 2) check(32'(pin_level[p]), 32'(l & ~lo));
      end
    end
    // Strong pull-up pulse after a rising latch in quasi type.
    for (int p = 0; p < 3; p++) begin
      @(posedge clk);
      bus(2'h1, ADDR_A[p], 8'h00);
      bus(2'h1, ADDR_B[p], 8'h00);
      bus(2'h0, 8'h00, 8'h00);
      port_latch[p] <= 8'h00;
      ext_bus_mode <= 1'b0;
      repeat (4) @(posedge clk);
      port_latch[p] <= 8'hFF;
      for (int k = 1; k < 5; k++) begin
        @(posedge clk);
        #1;
        check(32'(pin_drv[p].pu_strong), k < 3 ? 32'h000000FF : 32'h00000000);
      end
    end
    // A second reset clears every selection register; nonzero bytes first, so the clear is visible.
    @(posedge clk);
    for (int p = 0; p < 3; p++) begin
      bus(2'h1, ADDR_A[p], 8'($urandom) | 8'h01);
      bus(2'h1, ADDR_B[p], 8'($urandom) | 8'h01);
    end
    bus(2'h0, 8'h00, 8'h00);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    read_zero();
    bus(2'h0, 8'h00, 8'h00);
    repeat (2) @(posedge clk);
    // Every noted read must have been answered by now.
    check(32'(exp_q.size()), 32'h00000000);
    finish_test();
  end
endmodule
bind ciopd_top ciopd_top_asserts ciopd_top_asserts_inst (.clk(clk), .resetn(resetn), .sfr_addr(sfr_addr),
  .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
  .pin_in(pin_in), .pin_level(pin_level), .pin_drv(pin_drv));
`default_nettype wire
